//--- include/acr_defines.svh
// Purpose: offsets, field positions, reset values of the config registers
// Assumes: included by bare name
// Notes: register indices are word indices; byte address is index times 4
`ifndef ACR_DEFINES_SVH
`define ACR_DEFINES_SVH
`define ACR_IDX_STATUS 4'h1
`define ACR_IDX_MODE 4'h2
`define ACR_IDX_CLOCK 4'h3
`define ACR_MODE_RST 16'h0510
`define ACR_CLOCK_RST 16'h0f8e
`define ACR_MODE_WMASK 16'h3f12
`define ACR_CLOCK_WMASK 16'h0fff
`define ACR_BIT_REGCRC 13
`define ACR_BIT_RXCRC 12
`define ACR_BIT_CRCPOLY 11
`define ACR_BIT_RSTFLAG 10
`define ACR_BIT_WSZ_HI 9
`define ACR_BIT_WSZ_LO 8
`define ACR_BIT_TIMEOUT 4
`define ACR_BIT_FLOAT 1
`define ACR_BIT_CHAN_HI 11
`define ACR_BIT_CHAN_LO 8
`define ACR_BIT_CLKSEL 7
`define ACR_BIT_OSR_HI 4
`define ACR_BIT_OSR_LO 2
`define ACR_BIT_PWR_HI 1
`define ACR_BIT_PWR_LO 0
`define ACR_OSR_BASE_LOG2 7
`endif

//--- include/acr_pkg.sv
// Purpose: types for the mode and clock configuration registers
// Assumes: nothing
// Notes: constants live in acr_defines.svh
package acr_pkg;
  typedef enum logic [1:0] {
    ACR_WS_16 = 2'h0,
    ACR_WS_24 = 2'h1,
    ACR_WS_32_PAD = 2'h2,
    ACR_WS_32_SEXT = 2'h3
  } acr_wsize_t;
  typedef enum logic [1:0] {
    ACR_PWR_VLOW = 2'h0,
    ACR_PWR_LOW = 2'h1,
    ACR_PWR_HRES_A = 2'h2,
    ACR_PWR_HRES_B = 2'h3
  } acr_pwr_t;
  typedef struct packed {
    logic reg_crc_en;
    logic rx_crc_en;
    logic crc_ansi;
    logic reset_seen;
    acr_wsize_t word_size_select;
    logic timeout_en;
    logic ready_pin_float_select;
  } acr_mode_t;
  typedef struct packed {
    logic [3:0] chan_on;
    logic clk_external;
    logic [2:0] oversampling_ratio;
    acr_pwr_t power_level_select;
  } acr_clock_t;
  typedef enum logic [2:0] {
    ACR_ST_IDLE = 3'b001,
    ACR_ST_ACK = 3'b010,
    ACR_ST_DONE = 3'b100
  } acr_state_t;
endpackage

//--- design/acr_regs.sv
// Purpose: mode and clock configuration registers on Avalon-MM
// Assumes: single clock, synchronous active-low reset, clock enable
// Notes: one waitrequest-low cycle per access, answer one cycle after request
//
// Behaviour
// - mode register at index 02h, resets to 0510h
// - mode bit 13 enables register map crc check, reset 0
// - mode bit 12 enables incoming frame crc check, reset 0
// - mode bit 11 picks crc polynomial: 0 ccitt, 1 ansi
// - mode bit 10 reads 1 after reset; host writes 0 to clear
// - mode bits 9:8 pick word length, reset 01b (24 bits)
// - mode bit 4 enables serial timeout, reset 1
// - mode bit 1: ready pin idle high (0) or floating (1)
// - clock register at index 03h, resets to 0f8eh
// - clock bits 15:12 read-only, always zero
// - clock bits 11:8 enable channels 3 down to 0, reset on
// - clock bit 7 picks clock source: 0 internal, 1 external
// - clock bits 4:2 oversampling ratio 128 shifted by code
// - clock bits 1:0 power mode, 10b and 11b high resolution
// - status register mirrors word length, reset flag and crc polynomial
`timescale 1ns/10ps
`include "acr_defines.svh"
module acr_regs #(
  parameter int ADDR_W = 4,
  parameter int DATA_W = 32
) (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic i_ce,
  input wire logic [ADDR_W-1:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [DATA_W-1:0] i_writedata,
  input wire logic [3:0] i_byteenable,
  input wire logic i_data_avail,
  output logic [DATA_W-1:0] o_readdata,
  output logic o_waitrequest,
  output logic [1:0] o_response,
  output acr_pkg::acr_mode_t o_mode,
  output acr_pkg::acr_clock_t o_clock,
  output logic [15:0] o_osr_value,
  output logic o_conversion_ready_pin_out,
  output logic o_conversion_ready_pin_oe_n
);
  initial begin
    if (ADDR_W < 2 || ADDR_W > 16 || DATA_W != 32) begin
      $error("acr_regs: ADDR_W must be 2..16 and DATA_W 32");
    end
  end

  acr_pkg::acr_state_t state_r;
  logic [15:0] mode_r;
  logic [15:0] clock_r;
  logic [15:0] wdata16;
  logic [15:0] bmask;
  logic [15:0] rd16;
  logic hit;
  logic acc_go;

  // avalon word address; unmapped indices read zero with slave-error
  assign hit = (i_address == ADDR_W'(`ACR_IDX_STATUS))
            || (i_address == ADDR_W'(`ACR_IDX_MODE))
            || (i_address == ADDR_W'(`ACR_IDX_CLOCK));
  assign wdata16 = i_writedata[15:0];
  assign bmask = {{8{i_byteenable[1]}}, {8{i_byteenable[0]}}};
  assign acc_go = i_ce && (state_r == acr_pkg::ACR_ST_IDLE)
               && (i_read ^ i_write);

  // idle -> ack (waitrequest low one cycle) -> done (master drops request)
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      state_r <= acr_pkg::ACR_ST_IDLE;
    end else if (i_ce) begin
      case (state_r)
        acr_pkg::ACR_ST_IDLE: begin
          if (i_read ^ i_write) begin
            state_r <= acr_pkg::ACR_ST_ACK;
          end
        end
        acr_pkg::ACR_ST_ACK: begin
          state_r <= acr_pkg::ACR_ST_DONE;
        end
        acr_pkg::ACR_ST_DONE: begin
          state_r <= acr_pkg::ACR_ST_IDLE;
        end
        default: begin
          state_r <= acr_pkg::ACR_ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      o_waitrequest <= 1'b1;
    end else if (i_ce) begin
      o_waitrequest <= !acc_go;
    end
  end

  // write takes effect at the edge where waitrequest is sampled low
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      mode_r <= `ACR_MODE_RST;
    end else if (i_ce && state_r == acr_pkg::ACR_ST_ACK && i_write
                 && i_address == ADDR_W'(`ACR_IDX_MODE)) begin
      // reserved bits are kept at zero; host must write zeros anyway
      mode_r <= (mode_r & ~(bmask & `ACR_MODE_WMASK))
              | (wdata16 & bmask & `ACR_MODE_WMASK);
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      clock_r <= `ACR_CLOCK_RST;
    end else if (i_ce && state_r == acr_pkg::ACR_ST_ACK && i_write
                 && i_address == ADDR_W'(`ACR_IDX_CLOCK)) begin
      // top nibble is outside the write mask: writes there are dropped
      clock_r <= (clock_r & ~(bmask & `ACR_CLOCK_WMASK))
               | (wdata16 & bmask & `ACR_CLOCK_WMASK);
    end
  end

  always_comb begin
    rd16 = 16'h0000;
    if (i_address == ADDR_W'(`ACR_IDX_MODE)) begin
      rd16 = mode_r;
    end else if (i_address == ADDR_W'(`ACR_IDX_CLOCK)) begin
      rd16 = {4'h0, clock_r[11:0]};
    end else if (i_address == ADDR_W'(`ACR_IDX_STATUS)) begin
      rd16[`ACR_BIT_CRCPOLY] = mode_r[`ACR_BIT_CRCPOLY];
      rd16[`ACR_BIT_RSTFLAG] = mode_r[`ACR_BIT_RSTFLAG];
      rd16[`ACR_BIT_WSZ_HI:`ACR_BIT_WSZ_LO] =
        mode_r[`ACR_BIT_WSZ_HI:`ACR_BIT_WSZ_LO];
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      o_readdata <= '0;
      o_response <= 2'h0;
    end else if (i_ce) begin
      if (acc_go) begin
        o_readdata <= i_read ? {16'h0000, rd16} : '0;
        o_response <= hit ? 2'h0 : 2'h2;
      end else begin
        o_readdata <= '0;
        o_response <= 2'h0;
      end
    end
  end

  // decoded fields drive the rest of the converter
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      o_mode <= acr_pkg::acr_mode_t'(8'h53);
      o_clock <= acr_pkg::acr_clock_t'(10'h3ce);
    end else if (i_ce) begin
      o_mode.reg_crc_en <= mode_r[`ACR_BIT_REGCRC];
      o_mode.rx_crc_en <= mode_r[`ACR_BIT_RXCRC];
      o_mode.crc_ansi <= mode_r[`ACR_BIT_CRCPOLY];
      o_mode.reset_seen <= mode_r[`ACR_BIT_RSTFLAG];
      o_mode.word_size_select <= acr_pkg::acr_wsize_t'(
        mode_r[`ACR_BIT_WSZ_HI:`ACR_BIT_WSZ_LO]);
      o_mode.timeout_en <= mode_r[`ACR_BIT_TIMEOUT];
      o_mode.ready_pin_float_select <= mode_r[`ACR_BIT_FLOAT];
      o_clock.chan_on <= clock_r[`ACR_BIT_CHAN_HI:`ACR_BIT_CHAN_LO];
      o_clock.clk_external <= clock_r[`ACR_BIT_CLKSEL];
      o_clock.oversampling_ratio <=
        clock_r[`ACR_BIT_OSR_HI:`ACR_BIT_OSR_LO];
      o_clock.power_level_select <= acr_pkg::acr_pwr_t'(
        clock_r[`ACR_BIT_PWR_HI:`ACR_BIT_PWR_LO]);
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      o_osr_value <= 16'h0400;
    end else if (i_ce) begin
      o_osr_value <= 16'(16'h0001 << (`ACR_OSR_BASE_LOG2
        + 32'(clock_r[`ACR_BIT_OSR_HI:`ACR_BIT_OSR_LO])));
    end
  end

  // ready pin: low when data ready; idle drives high or floats (oe_n high)
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      o_conversion_ready_pin_out <= 1'b1;
      o_conversion_ready_pin_oe_n <= 1'b0;
    end else if (i_ce) begin
      o_conversion_ready_pin_out <= !i_data_avail;
      o_conversion_ready_pin_oe_n <=
        !i_data_avail && mode_r[`ACR_BIT_FLOAT];
    end
  end

  sequence s_mode_write;
    i_ce && state_r == acr_pkg::ACR_ST_ACK && i_write
      && i_address == ADDR_W'(`ACR_IDX_MODE) && i_byteenable[1];
  endsequence

  a_mode_reset_val: assert property (@(posedge i_clk_sys)
    $past(!i_nrst) && !$past(i_nrst, 2) |-> mode_r == 16'h0510)
    else $error("mode register reset value wrong");
  a_clock_reset_val: assert property (@(posedge i_clk_sys)
    $past(!i_nrst) |-> clock_r == 16'h0f8e)
    else $error("clock register reset value wrong");
  a_clock_top_zero: assert property (@(posedge i_clk_sys)
    disable iff (!i_nrst) clock_r[15:12] == 4'h0)
    else $error("clock top nibble not zero");
  a_mode_reserved_zero: assert property (@(posedge i_clk_sys)
    disable iff (!i_nrst) (mode_r & ~16'h3f12) == 16'h0000)
    else $error("mode reserved bits set");
  a_rstflag_clear: assert property (@(posedge i_clk_sys)
    disable iff (!i_nrst)
    s_mode_write and !i_writedata[10] |=> !mode_r[10])
    else $error("reset flag not cleared by write of zero");
  a_word_size_out: assert property (@(posedge i_clk_sys)
    disable iff (!i_nrst) i_ce |=> o_mode.word_size_select == $past(mode_r[9:8]))
    else $error("word size output does not follow register");
  a_status_mirror: assert property (@(posedge i_clk_sys)
    disable iff (!i_nrst) acc_go && i_read
      && i_address == ADDR_W'(`ACR_IDX_STATUS)
    |=> o_readdata[11:8] == $past(mode_r[11:8]) && !o_waitrequest)
    else $error("status mirror wrong");
  a_osr_value: assert property (@(posedge i_clk_sys)
    disable iff (!i_nrst) i_ce && $past(i_ce) |-> o_osr_value ==
      16'(16'h0080 << $past(clock_r[4:2])))
    else $error("oversampling ratio decode wrong");
  a_float_pin: assert property (@(posedge i_clk_sys)
    disable iff (!i_nrst) i_ce && !i_data_avail && mode_r[1]
    |=> o_conversion_ready_pin_oe_n)
    else $error("ready pin not floated while idle");
endmodule

//--- verif/acr_host.sv
// Purpose: host model issuing register bus transfers
// Assumes: each call starts right after a rising clock edge
// Notes: raw lets a scenario put ones into reserved bits on purpose
`timescale 1ns/10ps
module acr_host (
  input wire logic i_clk_sys,
  input wire logic i_waitrequest,
  input wire logic [31:0] i_readdata,
  input wire logic [1:0] i_response,
  output logic [3:0] o_address,
  output logic o_read,
  output logic o_write,
  output logic [31:0] o_writedata,
  output logic [3:0] o_byteenable
);
  initial begin
    o_address = 4'h0;
    o_read = 1'b0;
    o_write = 1'b0;
    o_writedata = 32'h0;
    o_byteenable = 4'h0;
  end
  task automatic xfer(input logic wr, input logic raw, input logic [3:0] a,
      input logic [15:0] d, input logic [3:0] be,
      output logic [31:0] q, output logic [1:0] rsp);
    logic [15:0] m;
    m = (a == 4'h3) ? 16'hff9f : 16'h3f12;
    o_address <= a;
    o_writedata <= {16'h0, raw ? d : (d & m)};
    o_byteenable <= be;
    o_write <= wr;
    o_read <= !wr;
    @(posedge i_clk_sys);
    while (i_waitrequest !== 1'b0) @(posedge i_clk_sys);
    q = i_readdata;
    rsp = i_response;
    o_write <= 1'b0;
    o_read <= 1'b0;
    // idle edge so the next raise never lands in the release time step
    @(posedge i_clk_sys);
  endtask
endmodule

//--- verif/adc_mode_clock_config_regs_bench.sv
// Purpose: self-checking bench for the configuration registers
// Assumes: host model drives the bus, bench drives the rest
// Notes: expectations are written out by hand per scenario
`timescale 1ns/10ps
module adc_mode_clock_config_regs_bench;
  logic i_clk_sys = 1'b0;
  logic i_nrst = 1'b0;
  logic i_ce = 1'b1;
  logic i_data_avail = 1'b0;
  logic [3:0] adr, be;
  logic rd_s, wr_s, wq;
  logic [31:0] wd, rdd, q;
  logic [1:0] rsp, r;
  int mismatches = 0;
  int compares = 0;
  always #20 i_clk_sys = ~i_clk_sys;
  acr_regs uut (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_ce(i_ce),
    .i_address(adr), .i_read(rd_s), .i_write(wr_s), .i_writedata(wd),
    .i_byteenable(be), .i_data_avail(i_data_avail), .o_readdata(rdd),
    .o_waitrequest(wq), .o_response(rsp), .o_mode(), .o_clock(),
    .o_osr_value(), .o_conversion_ready_pin_out(),
    .o_conversion_ready_pin_oe_n());
  acr_host host (.i_clk_sys(i_clk_sys), .i_waitrequest(wq),
    .i_readdata(rdd), .i_response(rsp), .o_address(adr), .o_read(rd_s),
    .o_write(wr_s), .o_writedata(wd), .o_byteenable(be));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
      input string what);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d,
      input logic raw);
    host.xfer(1'b1, raw, a, d, 4'h3, q, r);
  endtask
  task automatic rd(input logic [3:0] a);
    host.xfer(1'b0, 1'b0, a, 16'h0, 4'h3, q, r);
  endtask
  task automatic test_done();
    if (mismatches == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic t_reset();
    rd(4'h2);
    chk(q, 32'h0510, "mode reset");
    chk({30'h0, r}, 32'h0, "okay response");
    rd(4'h3);
    chk(q, 32'h0f8e, "clock reset");
    rd(4'h1);
    chk(q, 32'h0500, "status reset");
    chk({16'h0, uut.o_osr_value}, 32'd1024, "osr reset");
  endtask
  task automatic t_mode();
    logic [1:0] ws;
    wr(4'h2, 16'hffff, 1'b1);
    rd(4'h2);
    chk(q, 32'h3f12, "mode ones");
    chk({24'h0, uut.o_mode}, 32'hff, "mode decode");
    rd(4'h1);
    chk(q, 32'h0f00, "status mirror");
    for (int i = 0; i < 4; i++) begin
      ws = i[1:0];
      wr(4'h2, {6'h0, ws, 8'h0}, 1'b0);
      rd(4'h2);
      chk(q, {22'h0, ws, 8'h0}, "word size");
      chk({30'h0, uut.o_mode.word_size_select}, {30'h0, ws}, "ws");
      rd(4'h1);
      chk(q, {22'h0, ws, 8'h0}, "status ws");
    end
    host.xfer(1'b1, 1'b0, 4'h2, 16'h3f12, 4'h1, q, r);
    rd(4'h2);
    chk(q, 32'h0312, "low lane only");
  endtask
  task automatic t_clock();
    logic [2:0] k;
    logic [15:0] d;
    wr(4'h3, 16'hffff, 1'b1);
    rd(4'h3);
    chk(q, 32'h0fff, "clock top zero");
    for (int i = 0; i < 8; i++) begin
      k = i[2:0];
      d = {4'h0, 1'b0, k, k[0], 2'b00, k, k[1:0]};
      wr(4'h3, d, 1'b0);
      rd(4'h3);
      chk(q, {16'h0, d}, "clock rw");
      chk({16'h0, uut.o_osr_value}, 32'd128 << k, "osr");
      chk({22'h0, uut.o_clock}, {22'h0, d[11:7], d[4:0]}, "dec");
    end
  endtask
  task automatic t_pin();
    wr(4'h2, 16'h0000, 1'b0);
    repeat (3) @(posedge i_clk_sys);
    chk({uut.o_conversion_ready_pin_out, uut.o_conversion_ready_pin_oe_n},
      32'h2, "idle high");
    i_data_avail <= 1'b1;
    repeat (3) @(posedge i_clk_sys);
    chk({uut.o_conversion_ready_pin_out, uut.o_conversion_ready_pin_oe_n},
      32'h0, "data low");
    i_data_avail <= 1'b0;
    wr(4'h2, 16'h0002, 1'b0);
    repeat (3) @(posedge i_clk_sys);
    chk({31'h0, uut.o_conversion_ready_pin_oe_n}, 32'h1, "float");
  endtask
  task automatic t_unmapped();
    wr(4'h5, 16'hffff, 1'b1);
    chk({30'h0, r}, 32'h2, "unmapped write");
    rd(4'h5);
    chk({q[31:2], r}, 32'h2, "unmapped read");
    wr(4'h1, 16'hffff, 1'b1);
    rd(4'h1);
    chk(q, 32'h0, "status read only");
    rd(4'h2);
    chk(q, 32'h0002, "mode kept");
  endtask
  initial begin
    repeat (16) @(posedge i_clk_sys);
    i_nrst <= 1'b1;
    t_reset();
    t_mode();
    t_clock();
    t_pin();
    t_unmapped();
    i_nrst <= 1'b0;
    repeat (2) @(posedge i_clk_sys);
    i_nrst <= 1'b1;
    t_reset();
    test_done();
  end
  initial begin
    repeat (3000) @(posedge i_clk_sys);
    mismatches++;
    test_done();
  end
endmodule
